/* File: chan0_config_regs.sv */
// Purpose: AXI4-Lite register bank for channel 0 configuration and calibration
// Assumes: One write and one read under way at most; global coefficient is on aclk
// Notes: Unmapped or unaligned addresses answer DECERR and read as zero
// Contract
// R1 - Config bits 15:6 hold signed ten-bit phase delay in modulator cycles.
// R2 - Config bit 2 set disables this channel's DC filter; clear leaves global control.
// R3 - Config bits 1:0 pick normal, shorted, positive or negative test input.
// R4 - Config register resets to zero.
// R5 - Upper offset register holds offset bits 23:8, resets to zero.
// R6 - Lower offset register bits 15:8 hold offset bits 7:0; 7:0 reserved.
// R7 - Upper gain register holds gain bits 23:8 across all sixteen bits.
// R8 - Upper gain register resets to 8000h.
// R9 - Lower gain register bits 15:8 hold gain bits 7:0; 7:0 reserved.
// R10 - Global coefficient zero disables DC filter regardless of channel bit.
// R11 - Reserved bits read zero; software writes zeros.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "chan0_consts.svh"
module chan0_config_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] global_dc_filter_coeff,
  output chan0_pkg::chan0_settings_t settings,
  output logic dc_filter_active,
  output logic [3:0] input_route
);
  import chan0_pkg::*;

  localparam int NR = `NUM_REGS;
  localparam logic [5:0] REG_INDEX [NR] = '{`CHAN0_CFG_IDX, `CHAN0_OFF_HI_IDX, `CHAN0_OFF_LO_IDX,
                                            `CHAN0_GAIN_HI_IDX, `CHAN0_GAIN_LO_IDX};
  localparam logic [15:0] REG_MASK [NR] = '{`CFG_MASK, `FULL_MASK, `LOW_MASK,
                                           `FULL_MASK, `LOW_MASK};
  localparam logic [15:0] REG_RESET [NR] = '{`CFG_RST, `OFF_HI_RST, `OFF_LO_RST,
                                            `GAIN_HI_RST, `GAIN_LO_RST};

  // Shared address decode for both channels; no match means unmapped
  function automatic logic [NR-1:0] decode_sel(input logic [ADDR_W-1:0] addr);
    decode_sel = '0;
    for (int i = 0; i < NR; i++) begin
      if (addr[1:0] == 2'h0 && addr[ADDR_W-1:2] == (ADDR_W-2)'(REG_INDEX[i])) begin
        decode_sel[i] = 1'b1;
      end
    end
  endfunction : decode_sel

  logic [15:0] regs_reg [NR];
  logic [15:0] regs_next [NR];

  wr_state_t wr_state_reg, wr_state_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic aw_take, w_take, wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [NR-1:0] wr_sel;

  rd_state_t rd_state_reg, rd_state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic ar_take;
  logic [NR-1:0] rd_sel;

  // Address and data are taken in either order and held until both are in
  always_comb begin
    s_axi_awready = aclk_en && !aw_held_reg && (wr_state_reg == WR_IDLE);
    s_axi_wready = aclk_en && !w_held_reg && (wr_state_reg == WR_IDLE);
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wr_fire = aclk_en && (wr_state_reg == WR_IDLE) && (aw_held_reg || aw_take)
              && (w_held_reg || w_take);
    wr_sel = decode_sel(wr_addr);
  end

  // Write channel next state
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bresp_next = bresp_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    case (wr_state_reg)
      WR_IDLE: begin
        if (wr_fire) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          bresp_next = (wr_sel == '0) ? `RESP_DECERR : `RESP_OKAY;
          wr_state_next = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = WR_IDLE;
        end
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  // Write channel registers; reset wins over the clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bresp_reg <= `RESP_OKAY;
    end else if (aclk_en) begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_bvalid = (wr_state_reg == WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // One storage word per register; byte lanes 0 and 1 carry the 16 bits
  for (genvar g = 0; g < NR; g++) begin : g_reg
    always_comb begin
      regs_next[g] = regs_reg[g];
      if (wr_fire && wr_sel[g]) begin
        if (wr_strb[0]) begin
          regs_next[g][7:0] = wr_data[7:0];
        end
        if (wr_strb[1]) begin
          regs_next[g][15:8] = wr_data[15:8];
        end
        regs_next[g] = regs_next[g] & REG_MASK[g]; // R6 R9 R11
      end
    end

    // Reset values differ per register
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_reg[g] <= REG_RESET[g]; // R4 R8
      end else if (aclk_en) begin
        regs_reg[g] <= regs_next[g];
      end
    end
  end

  // Read channel: one read at a time, data registered
  always_comb begin
    s_axi_arready = aclk_en && (rd_state_reg == RD_IDLE);
    ar_take = s_axi_arvalid && s_axi_arready;
    rd_sel = decode_sel(s_axi_araddr);
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (ar_take) begin
          rdata_next = '0;
          for (int i = 0; i < NR; i++) begin
            if (rd_sel[i]) begin
              rdata_next = 32'(regs_reg[i]); // R11
            end
          end
          rresp_next = (rd_sel == '0) ? `RESP_DECERR : `RESP_OKAY;
          rd_state_next = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= '0;
      rresp_reg <= `RESP_OKAY;
    end else if (aclk_en) begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid = (rd_state_reg == RD_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Settings view; 24-bit words joined from upper and lower registers
  always_comb begin
    settings.phase_delay = regs_reg[`SLOT_CFG][`PHASE_MSB:`PHASE_LSB]; // R1
    settings.dc_filter_disable = regs_reg[`SLOT_CFG][`DCDIS_BIT]; // R2
    settings.input_select = input_select_t'(regs_reg[`SLOT_CFG][`SEL_MSB:`SEL_LSB]); // R3
    settings.offset_cal = {regs_reg[`SLOT_OFF_HI], regs_reg[`SLOT_OFF_LO][`LOW_MSB:`LOW_LSB]}; // R5 R6
    settings.gain_cal = {regs_reg[`SLOT_GAIN_HI], regs_reg[`SLOT_GAIN_LO][`LOW_MSB:`LOW_LSB]}; // R7 R9
  end

  // Routing and filter enable come out registered
  chan0_route_decode u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .settings(settings),
    .global_dc_filter_coeff(global_dc_filter_coeff),
    .dc_filter_active(dc_filter_active),
    .input_route(input_route)
  );

  // Checks on the settings and the bus
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_full_write(int slot);
    wr_fire && wr_sel[slot] && (wr_strb[1:0] == 2'h3);
  endsequence

  sequence s_cfg_read;
    ar_take && rd_sel[`SLOT_CFG];
  endsequence

  property p_phase_write;
    s_full_write(`SLOT_CFG) |=> settings.phase_delay == $past(wr_data[`PHASE_MSB:`PHASE_LSB]);
  endproperty
  a_phase_write: assert property (p_phase_write) else $error("phase delay not stored"); // R1

  property p_dc_disable;
    aclk_en && settings.dc_filter_disable |=> !dc_filter_active;
  endproperty
  a_dc_disable: assert property (p_dc_disable) else $error("channel disable ignored"); // R2

  property p_dc_global;
    aclk_en && !settings.dc_filter_disable && global_dc_filter_coeff != `DC_COEFF_OFF
      |=> dc_filter_active;
  endproperty
  a_dc_global: assert property (p_dc_global) else $error("filter not under global control"); // R2

  property p_route;
    aclk_en |=> input_route == (`ROUTE_NORMAL << $past(settings.input_select));
  endproperty
  a_route: assert property (p_route) else $error("input routing wrong"); // R3

  property p_cfg_reset;
    $past(!aresetn) |-> regs_reg[`SLOT_CFG] == `CFG_RST && input_route == `ROUTE_NORMAL;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong"); // R4

  property p_offset_write;
    s_full_write(`SLOT_OFF_HI) |=> settings.offset_cal[23:8] == $past(wr_data[15:0]);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("offset upper not stored"); // R5

  property p_offset_low;
    s_full_write(`SLOT_OFF_LO) |=> settings.offset_cal[7:0] == $past(wr_data[15:8])
      && regs_reg[`SLOT_OFF_LO][7:0] == 8'h00;
  endproperty
  a_offset_low: assert property (p_offset_low) else $error("offset lower wrong"); // R6

  property p_gain_write;
    s_full_write(`SLOT_GAIN_HI) |=> settings.gain_cal[23:8] == $past(wr_data[15:0]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain upper not stored"); // R7

  property p_gain_reset;
    $past(!aresetn) |-> settings.gain_cal == {`GAIN_HI_RST, 8'h00};
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset value wrong"); // R8

  property p_gain_low;
    s_full_write(`SLOT_GAIN_LO) |=> settings.gain_cal[7:0] == $past(wr_data[15:8])
      && regs_reg[`SLOT_GAIN_LO][7:0] == 8'h00;
  endproperty
  a_gain_low: assert property (p_gain_low) else $error("gain lower wrong"); // R9

  property p_global_off;
    aclk_en && global_dc_filter_coeff == `DC_COEFF_OFF |=> !dc_filter_active;
  endproperty
  a_global_off: assert property (p_global_off) else $error("filter active with zero coeff"); // R10

  property p_cfg_read_rsvd;
    s_cfg_read |=> s_axi_rvalid && s_axi_rdata[`RSVD_MSB:`RSVD_LSB] == 3'h0
      && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_cfg_read_rsvd: assert property (p_cfg_read_rsvd) else $error("reserved bits read nonzero"); // R11

  property p_resp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
endmodule : chan0_config_regs

/* File: chan0_consts.svh */
// Purpose: Named offsets, field positions, masks and reset values for channel 0 registers
// Assumes: Included by bare name from the package and the register modules
// Notes: Register indices are word indices; the byte address is four times the index
`ifndef CHAN0_CONSTS_SVH
`define CHAN0_CONSTS_SVH

// Word indices of the channel 0 registers
`define CHAN0_CFG_IDX 6'h09
`define CHAN0_OFF_HI_IDX 6'h0a
`define CHAN0_OFF_LO_IDX 6'h0b
`define CHAN0_GAIN_HI_IDX 6'h0c
`define CHAN0_GAIN_LO_IDX 6'h0d

// Storage slots inside the register array
`define SLOT_CFG 0
`define SLOT_OFF_HI 1
`define SLOT_OFF_LO 2
`define SLOT_GAIN_HI 3
`define SLOT_GAIN_LO 4
`define NUM_REGS 5

// Field positions
`define PHASE_MSB 15
`define PHASE_LSB 6
`define RSVD_MSB 5
`define RSVD_LSB 3
`define DCDIS_BIT 2
`define SEL_MSB 1
`define SEL_LSB 0
`define LOW_MSB 15
`define LOW_LSB 8

// Writable bit masks, reserved bits cleared
`define CFG_MASK 16'hffc7
`define FULL_MASK 16'hffff
`define LOW_MASK 16'hff00

// Reset values
`define CFG_RST 16'h0000
`define OFF_HI_RST 16'h0000
`define OFF_LO_RST 16'h0000
`define GAIN_HI_RST 16'h8000
`define GAIN_LO_RST 16'h0000

// Bus answers and misc values
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define DC_COEFF_OFF 4'h0
`define ROUTE_NORMAL 4'h1

`endif

/* File: chan0_pkg.sv */
// Purpose: Types shared by the channel 0 register bank and its decoder
// Assumes: Constants come from chan0_consts.svh
// Notes: Settings travel as one packed struct
package chan0_pkg;
  `include "chan0_consts.svh"

  typedef enum logic [1:0] {
    SEL_NORMAL = 2'h0,
    SEL_SHORTED = 2'h1,
    SEL_POS_TEST = 2'h2,
    SEL_NEG_TEST = 2'h3
  } input_select_t;

  typedef struct packed {
    logic [9:0] phase_delay;
    logic dc_filter_disable;
    input_select_t input_select;
    logic [23:0] offset_cal;
    logic [23:0] gain_cal;
  } chan0_settings_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;
endpackage : chan0_pkg

/* File: chan0_route_decode.sv */
// Purpose: Registers the effective DC-filter enable and one-hot input routing for channel 0
// Assumes: Settings and global coefficient come from logic on aclk
// Notes: Outputs lag the settings by one enabled clock
`timescale 1ns/1ps
`include "chan0_consts.svh"
module chan0_route_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire chan0_pkg::chan0_settings_t settings,
  input wire logic [3:0] global_dc_filter_coeff,
  output logic dc_filter_active,
  output logic [3:0] input_route
);
  import chan0_pkg::*;

  logic dc_active_reg, dc_active_next;
  logic [3:0] route_reg, route_next;

  // Global zero coefficient overrides the per-channel bit
  always_comb begin
    dc_active_next = (global_dc_filter_coeff != `DC_COEFF_OFF) // R10
                     && !settings.dc_filter_disable; // R2
    route_next = `ROUTE_NORMAL << settings.input_select; // R3
  end

  // Frozen while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dc_active_reg <= 1'b0;
      route_reg <= `ROUTE_NORMAL;
    end else if (aclk_en) begin
      dc_active_reg <= dc_active_next;
      route_reg <= route_next;
    end
  end

  assign dc_filter_active = dc_active_reg;
  assign input_route = route_reg;
endmodule : chan0_route_decode

/* File: channel_zero_config_calibration_regs_tb_top.sv */
// Purpose: Self-checking bench for the channel 0 configuration and calibration registers
// Assumes: Registers reached over AXI4-Lite; byte address is four times the word index
// Notes: Clock enable dropped once to show the freeze; global coefficient is a bench level
`timescale 1ns/1ps
module channel_zero_config_calibration_regs_tb_top;
  import chan0_pkg::*;

  // Word indices of the five registers
  localparam int CFG_IDX = 9;
  localparam int OFF_HI_IDX = 10;
  localparam int OFF_LO_IDX = 11;
  localparam int GAIN_HI_IDX = 12;
  localparam int GAIN_LO_IDX = 13;

  logic aclk;
  logic aresetn;
  logic aclk_en;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [3:0] global_dc_filter_coeff;
  chan0_settings_t settings;
  logic dc_filter_active;
  logic [3:0] input_route;
  int fail_count;
  int num_checks;

  chan0_config_regs #(.ADDR_W(8)) u_chan0_config_regs (
    .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .global_dc_filter_coeff(global_dc_filter_coeff), .settings(settings),
    .dc_filter_active(dc_filter_active), .input_route(input_route)
  );

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Compare and count; an unknown never matches
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Write with both channels offered together, released each as it is taken
  task automatic axi_write(input logic [7:0] addr, input logic [15:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    logic b_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    resp = 2'h2;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, data};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !b_done; n++) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (aw_done && w_done && s_axi_bvalid === 1'b1) begin
        b_done = 1'b1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    check("write_done", {31'h0, b_done}, 32'h1);
  endtask : axi_write

  // Read; rready held until rvalid is sampled
  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic ar_done;
    logic r_done;
    ar_done = 1'b0;
    r_done = 1'b0;
    data = 32'hdead_beef;
    resp = 2'h2;
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !r_done; n++) begin
      @(posedge aclk);
      if (!ar_done && s_axi_arready === 1'b1) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end else if (ar_done && s_axi_rvalid === 1'b1) begin
        r_done = 1'b1;
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    check("read_done", {31'h0, r_done}, 32'h1);
  endtask : axi_read

  // Mapped-register shorthands expecting an OKAY answer
  task automatic wr(input int idx, input logic [15:0] data);
    logic [1:0] resp;
    axi_write(8'(4 * idx), data, 4'h3, resp);
    check("bresp", {30'h0, resp}, 32'h0);
  endtask : wr

  task automatic rd(input int idx, input logic [31:0] exp);
    logic [31:0] data;
    logic [1:0] resp;
    axi_read(8'(4 * idx), data, resp);
    check("rresp", {30'h0, resp}, 32'h0);
    check("rdata", data, exp);
  endtask : rd

  // Lets settings and the registered decoder outputs land
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  task automatic do_reset(input int cycles);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (cycles) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic t_reset_values;
    rd(CFG_IDX, 32'h0000);
    rd(OFF_HI_IDX, 32'h0000);
    rd(OFF_LO_IDX, 32'h0000);
    rd(GAIN_HI_IDX, 32'h8000);
    rd(GAIN_LO_IDX, 32'h0000);
    settle();
    check("gain_cal_rst", {8'h0, settings.gain_cal}, 32'h0080_0000);
    check("route_rst", {28'h0, input_route}, 32'h1);
  endtask : t_reset_values

  // Phase field, reserved bits and every input selection
  task automatic t_config;
    wr(CFG_IDX, 16'hffff);
    rd(CFG_IDX, 32'hffc7);
    settle();
    check("phase_neg1", {22'h0, settings.phase_delay}, 32'h3ff);
    check("dc_dis_set", {31'h0, settings.dc_filter_disable}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(CFG_IDX, {10'h201, 3'b000, 1'b0, 2'(s)});
      rd(CFG_IDX, {16'h0, 10'h201, 4'b0000, 2'(s)});
      settle();
      check("input_select", {30'h0, settings.input_select}, 32'(s));
      check("input_route", {28'h0, input_route}, 32'h1 << s);
      check("phase_field", {22'h0, settings.phase_delay}, 32'h201);
    end
  endtask : t_config

  // Calibration halves pair into 24-bit words; reserved low bytes drop
  task automatic t_cal;
    logic [1:0] resp;
    wr(OFF_HI_IDX, 16'h1234);
    wr(OFF_LO_IDX, 16'habff);
    wr(GAIN_HI_IDX, 16'h7e5a);
    wr(GAIN_LO_IDX, 16'hc3ff);
    rd(OFF_HI_IDX, 32'h1234);
    rd(OFF_LO_IDX, 32'hab00);
    rd(GAIN_HI_IDX, 32'h7e5a);
    rd(GAIN_LO_IDX, 32'hc300);
    settle();
    check("offset_cal", {8'h0, settings.offset_cal}, 32'h0012_34ab);
    check("gain_cal", {8'h0, settings.gain_cal}, 32'h007e_5ac3);
    axi_write(8'(4 * GAIN_HI_IDX), 16'h9966, 4'h1, resp);
    check("bresp_lane", {30'h0, resp}, 32'h0);
    rd(GAIN_HI_IDX, 32'h7e66);
  endtask : t_cal

  // Channel disable against the global coefficient
  task automatic t_dc;
    wr(CFG_IDX, 16'h0000);
    global_dc_filter_coeff <= 4'h0;
    settle();
    check("dc_coeff0", {31'h0, dc_filter_active}, 32'h0);
    @(posedge aclk);
    global_dc_filter_coeff <= 4'h5;
    settle();
    check("dc_global", {31'h0, dc_filter_active}, 32'h1);
    wr(CFG_IDX, 16'h0004);
    settle();
    check("dc_chan_dis", {31'h0, dc_filter_active}, 32'h0);
    @(posedge aclk);
    global_dc_filter_coeff <= 4'h0;
    wr(CFG_IDX, 16'h0000);
    settle();
    check("dc_coeff0_b", {31'h0, dc_filter_active}, 32'h0);
    // Enable low freezes the decoder; the new coefficient only lands once it returns
    @(posedge aclk);
    aclk_en <= 1'b0;
    global_dc_filter_coeff <= 4'h5;
    settle();
    check("dc_frozen", {31'h0, dc_filter_active}, 32'h0);
    @(posedge aclk);
    aclk_en <= 1'b1;
    settle();
    check("dc_thawed", {31'h0, dc_filter_active}, 32'h1);
  endtask : t_dc

  // Unmapped and unaligned places answer an error and leave the bank alone
  task automatic t_decerr;
    logic [31:0] data;
    logic [1:0] resp;
    wr(CFG_IDX, 16'h0042);
    axi_write(8'h38, 16'hffff, 4'h3, resp);
    check("bresp_unmapped", {30'h0, resp}, 32'h3);
    axi_write(8'h25, 16'hffff, 4'h3, resp);
    check("bresp_unaligned", {30'h0, resp}, 32'h3);
    axi_read(8'h38, data, resp);
    check("rresp_unmapped", {30'h0, resp}, 32'h3);
    check("rdata_unmapped", data, 32'h0);
    rd(CFG_IDX, 32'h0042);
  endtask : t_decerr

  // A second reset mid-run restores documented values
  task automatic t_reset_mid;
    wr(GAIN_HI_IDX, 16'h1111);
    wr(CFG_IDX, 16'hffff);
    do_reset(2);
    rd(GAIN_HI_IDX, 32'h8000);
    rd(CFG_IDX, 32'h0000);
    rd(OFF_HI_IDX, 32'h0000);
  endtask : t_reset_mid

  // Main sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    aresetn = 1'b0;
    aclk_en = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    global_dc_filter_coeff = 4'h1;
    do_reset(6);
    t_reset_values();
    t_config();
    t_cal();
    t_dc();
    t_decerr();
    t_reset_mid();
    final_report();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule : channel_zero_config_calibration_regs_tb_top
